// ==== core/mic_core.v ====
// Interrupt routing, pin drive, event detection and sample buffer of a
// three-axis motion sensor. Assumes a byte register port decoded from the
// serial bus outside, and 10-bit signed samples with a done strobe.
`timescale 1ns/1ns
`include "mic_defs.vh"
module mic_core #(
  parameter MS_CYCLES = `MIC_MS_NS / `MIC_CLK_NS,
  parameter DRDY_CYCLES = `MIC_DRDY_PULSE_NS / `MIC_CLK_NS,
  parameter [7:0] CHIP_ID = 8'h5A
) (
  // Clock and reset
  input wire clk,
  input wire srst,
  // Register port
  input wire regWr,
  input wire regRd,
  input wire [7:0] regAddr,
  input wire [7:0] regWrData,
  output reg [7:0] regRdData,
  output reg regRdValid,
  // Sample path
  input wire convStart,
  input wire sampleReady,
  input wire [29:0] sampleXyz,
  input wire [1:0] fullScale,
  // Interrupt pins
  output reg irqAOut,
  output reg irqAOe,
  output reg irqBOut,
  output reg irqBOe
);
  localparam ST_IDLE = 4'b0001;
  localparam ST_SHOCK = 4'b0010;
  localparam ST_QUIET = 4'b0100;
  localparam ST_WAIT2 = 4'b1000;

  reg [7:0] pinDriveCfg, irqBehCfg, ffDelay, ffThr, hystMode, shDelay, shThr;
  reg [23:0] trim;
  reg [7:0] knockTime, knockThr, orientZThr, routeB, bufMode;

  always @(posedge clk) begin
    if (srst) begin
      pinDriveCfg <= `MIC_RST_PIN_DRIVE;
      irqBehCfg <= `MIC_RST_IRQ_BEH;
      ffDelay <= `MIC_RST_FF_DELAY;
      ffThr <= `MIC_RST_FF_THR;
      hystMode <= `MIC_RST_HYST_MODE;
      shDelay <= `MIC_RST_SH_DELAY;
      shThr <= `MIC_RST_SH_THR;
      trim <= {3{`MIC_RST_ZERO}};
      knockTime <= `MIC_RST_KNOCK_TIME;
      knockThr <= `MIC_RST_ZERO;
      orientZThr <= `MIC_RST_ZERO;
      routeB <= `MIC_RST_ZERO;
      bufMode <= `MIC_RST_ZERO;
    end else if (regWr) begin
      case (regAddr)
        `MIC_ADDR_ROUTE_B: routeB <= regWrData;
        `MIC_ADDR_PIN_DRIVE: pinDriveCfg <= regWrData;
        `MIC_ADDR_IRQ_BEH: irqBehCfg <= regWrData;
        `MIC_ADDR_FF_DELAY: ffDelay <= regWrData;
        `MIC_ADDR_FF_THR: ffThr <= regWrData;
        `MIC_ADDR_HYST_MODE: hystMode <= regWrData;
        `MIC_ADDR_SH_DELAY: shDelay <= regWrData;
        `MIC_ADDR_SH_THR: shThr <= regWrData;
        `MIC_ADDR_X_TRIM: trim[7:0] <= regWrData;
        `MIC_ADDR_Y_TRIM: trim[15:8] <= regWrData;
        `MIC_ADDR_Z_TRIM: trim[23:16] <= regWrData;
        `MIC_ADDR_KNOCK_TIME: knockTime <= regWrData;
        `MIC_ADDR_KNOCK_THR: knockThr <= {3'h0, regWrData[4:0]};
        `MIC_ADDR_ORIENT_Z: orientZThr <= regWrData;
        `MIC_ADDR_BUF_MODE: bufMode <= regWrData;
        default: ;
      endcase
    end
  end

  // Range shift: 2g, 4g, 8g; the reserved code behaves as 8g
  wire [1:0] rangeSh = (fullScale == 2'h3) ? 2'h2 : fullScale;
  wire shadowOff = irqBehCfg[`MIC_BYTE_LOCK_DISABLE];

  wire [29:0] accAll;
  wire [2:0] newAll, lockAll;
  wire [23:0] frozenAll;
  wire [38:0] magAll;

  genvar ax;
  generate
    for (ax = 0; ax < 3; ax = ax + 1) begin : gAxis
      wire signed [9:0] raw = sampleXyz[10*ax +: 10];
      wire signed [7:0] ofs = trim[8*ax +: 8];
      wire signed [10:0] sum = raw + ofs;
      reg [9:0] acc;
      reg newData, locked;
      reg [7:0] frozen;
      wire [9:0] mag = acc[9] ? (~acc + 10'h001) : acc;
      always @(posedge clk) begin
        if (srst) begin
          acc <= 10'h000;
          newData <= 1'b0;
          locked <= 1'b0;
          frozen <= 8'h00;
        end else begin
          if (sampleReady) begin
            acc <= (sum > 11'sd511) ? 10'h1FF : (sum < -11'sd512) ? 10'h200 : sum[9:0];
            newData <= 1'b1;
          end
          if (regRd && regAddr == 8'h01 + 2 * ax) begin
            newData <= sampleReady;
            if (!shadowOff) begin
              locked <= 1'b1;
              frozen <= acc[9:2];
            end
          end
          if (regRd && regAddr == 8'h02 + 2 * ax) begin
            locked <= 1'b0;
          end
        end
      end
      assign accAll[10*ax +: 10] = acc;
      assign newAll[ax] = newData;
      assign lockAll[ax] = locked & ~shadowOff;
      assign frozenAll[8*ax +: 8] = frozen;
      assign magAll[13*ax +: 13] = {3'h0, mag} << rangeSh;
    end
  endgenerate

  // Magnitudes in units of 3.9 mg
  wire [12:0] mx = magAll[12:0], my = magAll[25:13], mz = magAll[38:26];
  wire [12:0] maxMxy = (mx > my) ? mx : my;
  wire [12:0] maxMag = (maxMxy > mz) ? maxMxy : mz;
  wire [13:0] sumMag = {1'b0, mx} + {1'b0, my} + {1'b0, mz};

  wire [13:0] ffMetric = hystMode[`MIC_FF_SUM_MODE] ? sumMag : {1'b0, maxMag};
  wire [13:0] ffThrU = {6'h00, ffThr} * `MIC_THR_UNIT;
  wire [13:0] ffHyst = {12'h000, hystMode[1:0]} * `MIC_HYST_UNIT;
  wire [13:0] shThrU = ({6'h00, shThr} * `MIC_THR_UNIT) << rangeSh;
  wire [13:0] shHyst = ({12'h000, hystMode[7:6]} * `MIC_HYST_UNIT) << rangeSh;
  wire [13:0] shLow = (shThrU > shHyst) ? shThrU - shHyst : 14'h0000;
  wire [13:0] knockThrU = ({9'h000, knockThr[4:0]} * `MIC_KNOCK_UNIT) << rangeSh;

  // Millisecond enable
  reg [16:0] msDiv;
  wire msTick = (msDiv == MS_CYCLES - 1);
  always @(posedge clk) begin
    if (srst || msTick) begin
      msDiv <= 17'h0_0000;
    end else begin
      msDiv <= msDiv + 17'h0_0001;
    end
  end

  // Evaluate detectors the cycle after a sample lands in the axis registers
  reg evalTick, ffCond, shCond;
  reg [9:0] ffMs, shMs;
  wire [9:0] ffTarget = ({2'h0, ffDelay} + 10'h001) * `MIC_DELAY_STEP_MS;
  wire [9:0] shTarget = ({2'h0, shDelay} + 10'h001) * `MIC_DELAY_STEP_MS;
  wire ffLive = ffCond && (ffMs >= ffTarget);
  wire shLive = shCond && (shMs >= shTarget);
  always @(posedge clk) begin
    if (srst) begin
      evalTick <= 1'b0;
      ffCond <= 1'b0;
      shCond <= 1'b0;
      ffMs <= 10'h000;
      shMs <= 10'h000;
    end else begin
      evalTick <= sampleReady;
      if (evalTick) begin
        ffCond <= ffCond ? (ffMetric <= ffThrU + ffHyst) : (ffMetric < ffThrU);
        shCond <= shCond ? ({1'b0, maxMag} >= shLow) : ({1'b0, maxMag} > shThrU);
      end
      if (!ffCond) begin
        ffMs <= 10'h000;
      end else if (msTick && ffMs < ffTarget) begin
        ffMs <= ffMs + 10'h001;
      end
      if (!shCond) begin
        shMs <= 10'h000;
      end else if (msTick && shMs < shTarget) begin
        shMs <= shMs + 10'h001;
      end
    end
  end

  // Knock detection
  reg [3:0] knockState;
  reg [9:0] knockMs;
  reg singleKnock, doubleKnock;
  reg [9:0] windowMs;
  wire knockHit = evalTick && ({1'b0, maxMag} > knockThrU);
  wire [9:0] shockMs = knockTime[6] ? `MIC_SHOCK_SHORT_MS : `MIC_SHOCK_LONG_MS;
  wire [9:0] quietMs = knockTime[7] ? `MIC_QUIET_LONG_MS : `MIC_QUIET_SHORT_MS;
  always @* begin
    case (knockTime[2:0])
      3'h0: windowMs = 10'd50;
      3'h1: windowMs = 10'd100;
      3'h2: windowMs = 10'd150;
      3'h3: windowMs = 10'd200;
      3'h4: windowMs = 10'd250;
      3'h5: windowMs = 10'd375;
      3'h6: windowMs = 10'd500;
      default: windowMs = 10'd700;
    endcase
  end
  wire knockDone = msTick && (knockMs == 10'h000);
  always @(posedge clk) begin
    if (srst) begin
      knockState <= ST_IDLE;
      knockMs <= 10'h000;
      singleKnock <= 1'b0;
      doubleKnock <= 1'b0;
    end else begin
      singleKnock <= 1'b0;
      doubleKnock <= 1'b0;
      if (msTick && knockMs != 10'h000) begin
        knockMs <= knockMs - 10'h001;
      end
      case (knockState)
        ST_IDLE: if (knockHit) begin
          knockState <= ST_SHOCK;
          knockMs <= shockMs;
        end
        ST_SHOCK: if (knockDone) begin
          knockState <= ST_QUIET;
          knockMs <= quietMs;
        end
        // A hit while it should be quiet means vibration, not a knock
        ST_QUIET: if (knockHit) begin
          knockState <= ST_IDLE;
        end else if (knockDone) begin
          singleKnock <= 1'b1;
          knockState <= ST_WAIT2;
          knockMs <= windowMs;
        end
        ST_WAIT2: if (knockHit) begin
          doubleKnock <= 1'b1;
          knockState <= ST_IDLE;
        end else if (knockDone) begin
          knockState <= ST_IDLE;
        end
        default: knockState <= ST_IDLE;
      endcase
    end
  end

  // Data ready
  reg drdyLive;
  reg [13:0] drdyCnt;
  always @(posedge clk) begin
    if (srst) begin
      drdyLive <= 1'b0;
      drdyCnt <= 14'h0000;
    end else if (sampleReady) begin
      drdyLive <= 1'b1;
      drdyCnt <= 14'h0000;
    end else if (irqBehCfg[`MIC_DRDY_HOLD]) begin
      if (convStart) begin
        drdyLive <= 1'b0;
      end
    end else if (drdyLive) begin
      drdyCnt <= drdyCnt + 14'h0001;
      if (drdyCnt == DRDY_CYCLES - 1) begin
        drdyLive <= 1'b0;
      end
    end
  end

  // Sample buffer
  reg [6:0] wrPtr, rdPtr, entries;
  reg [1:0] pushLeft, pushAxis;
  reg byteHi, overrun;
  wire [9:0] memRd;
  wire allAxes = (bufMode[1:0] == 2'h0);
  wire [6:0] perFrame = allAxes ? 7'h03 : 7'h01;
  wire [6:0] frames = allAxes ? entries / 7'h03 : entries;
  wire bufFull = (frames == `MIC_BUF_FRAMES);
  wire bufWm = (frames >= `MIC_BUF_WATERMARK);
  wire push = (pushLeft != 2'h0);
  wire bufRead = regRd && regAddr == `MIC_ADDR_BUF_READ && entries != 7'h00;
  wire pop = bufRead && byteHi;
  wire bufFlush = regWr && regAddr == `MIC_ADDR_BUF_MODE;
  always @(posedge clk) begin
    if (srst || bufFlush) begin
      wrPtr <= 7'h00;
      rdPtr <= 7'h00;
      entries <= 7'h00;
      pushLeft <= 2'h0;
      pushAxis <= 2'h0;
      byteHi <= 1'b0;
      overrun <= 1'b0;
    end else begin
      if (sampleReady && !push) begin
        if ({1'b0, entries} + {1'b0, perFrame} <= `MIC_BUF_WORDS) begin
          pushLeft <= perFrame[1:0];
          pushAxis <= allAxes ? 2'h0 : bufMode[1:0] - 2'h1;
        end else begin
          overrun <= 1'b1;
        end
      end else if (push) begin
        pushLeft <= pushLeft - 2'h1;
        pushAxis <= pushAxis + 2'h1;
        wrPtr <= (wrPtr == `MIC_BUF_WORDS - 1) ? 7'h00 : wrPtr + 7'h01;
      end
      if (bufRead) begin
        byteHi <= ~byteHi;
      end
      if (pop) begin
        rdPtr <= (rdPtr == `MIC_BUF_WORDS - 1) ? 7'h00 : rdPtr + 7'h01;
      end
      entries <= entries + {6'h00, push} - {6'h00, pop};
    end
  end

  mic_fifo_mem uMem (
    .clk(clk),
    .wrEn(push),
    .wrAddr(wrPtr),
    .wrData(accAll[10*pushAxis +: 10]),
    .rdAddr(rdPtr),
    .rdData(memRd)
  );

  // Event status
  wire [7:0] liveB, liveA;
  assign liveB = ({7'h00, bufWm} << `MIC_EV_WATERMARK) | ({7'h00, bufFull} << `MIC_EV_FULL)
    | ({7'h00, drdyLive} << `MIC_EV_DATA) | ({7'h00, ffLive} << `MIC_EV_FREEFALL)
    | ({7'h00, shLive} << `MIC_EV_SHOCK);
  assign liveA = ({7'h00, singleKnock} << `MIC_EV_SINGLE_KNOCK)
    | ({7'h00, doubleKnock} << `MIC_EV_DOUBLE_KNOCK);
  reg [7:0] stickyA, stickyB;
  wire statRead = regAddr == `MIC_ADDR_STAT_A || regAddr == `MIC_ADDR_STAT_B;
  wire clearAll = regRd && (irqBehCfg[`MIC_CLEAR_ON_ANY_READ] || statRead);
  wire latchOn = irqBehCfg[`MIC_LATCH];
  always @(posedge clk) begin
    if (srst) begin
      stickyA <= 8'h00;
      stickyB <= 8'h00;
    end else begin
      // Set beats a clear in the same cycle
      stickyA <= liveA | (stickyA & {8{~clearAll}});
      stickyB <= liveB | (stickyB & {8{~clearAll}});
    end
  end
  wire [7:0] statA = latchOn ? stickyA : liveA;
  wire [7:0] statB = latchOn ? stickyB : liveB;

  // Pin drive
  wire activeA = |statA;
  wire activeB = |(statB & routeB);
  wire levelA = activeA ? pinDriveCfg[`MIC_PIN_A_POLARITY] : ~pinDriveCfg[`MIC_PIN_A_POLARITY];
  wire levelB = activeB ? pinDriveCfg[`MIC_PIN_B_POLARITY] : ~pinDriveCfg[`MIC_PIN_B_POLARITY];
  always @(posedge clk) begin
    if (srst) begin
      irqAOut <= 1'b0;
      irqAOe <= 1'b1;
      irqBOut <= 1'b0;
      irqBOe <= 1'b1;
    end else begin
      irqAOut <= levelA & ~pinDriveCfg[`MIC_PIN_A_OPENDRAIN];
      irqAOe <= ~pinDriveCfg[`MIC_PIN_A_OPENDRAIN] | ~levelA;
      irqBOut <= levelB & ~pinDriveCfg[`MIC_PIN_B_OPENDRAIN];
      irqBOe <= ~pinDriveCfg[`MIC_PIN_B_OPENDRAIN] | ~levelB;
    end
  end

  // Read mux
  reg [7:0] rdMux;
  always @* begin
    case (regAddr)
      `MIC_ADDR_ID: rdMux = CHIP_ID;
      8'h01: rdMux = {accAll[1:0], 5'h00, newAll[0]};
      8'h02: rdMux = lockAll[0] ? frozenAll[7:0] : accAll[9:2];
      8'h03: rdMux = {accAll[11:10], 5'h00, newAll[1]};
      8'h04: rdMux = lockAll[1] ? frozenAll[15:8] : accAll[19:12];
      8'h05: rdMux = {accAll[21:20], 5'h00, newAll[2]};
      8'h06: rdMux = lockAll[2] ? frozenAll[23:16] : accAll[29:22];
      `MIC_ADDR_STAT_A: rdMux = statA;
      `MIC_ADDR_STAT_B: rdMux = statB;
      `MIC_ADDR_BUF_STATE: rdMux = {overrun, frames};
      `MIC_ADDR_ROUTE_B: rdMux = routeB;
      `MIC_ADDR_PIN_DRIVE: rdMux = pinDriveCfg;
      `MIC_ADDR_IRQ_BEH: rdMux = irqBehCfg;
      `MIC_ADDR_FF_DELAY: rdMux = ffDelay;
      `MIC_ADDR_FF_THR: rdMux = ffThr;
      `MIC_ADDR_HYST_MODE: rdMux = hystMode;
      `MIC_ADDR_SH_DELAY: rdMux = shDelay;
      `MIC_ADDR_SH_THR: rdMux = shThr;
      `MIC_ADDR_X_TRIM: rdMux = trim[7:0];
      `MIC_ADDR_Y_TRIM: rdMux = trim[15:8];
      `MIC_ADDR_Z_TRIM: rdMux = trim[23:16];
      `MIC_ADDR_KNOCK_TIME: rdMux = knockTime;
      `MIC_ADDR_KNOCK_THR: rdMux = knockThr;
      `MIC_ADDR_ORIENT_Z: rdMux = orientZThr;
      `MIC_ADDR_BUF_MODE: rdMux = bufMode;
      `MIC_ADDR_BUF_READ: begin
        if (entries == 7'h00) begin
          rdMux = 8'h00;
        end else if (byteHi) begin
          rdMux = memRd[9:2];
        end else begin
          rdMux = {memRd[1:0], 5'h00, 1'b1};
        end
      end
      default: rdMux = 8'h00;
    endcase
  end

  always @(posedge clk) begin
    if (srst) begin
      regRdData <= 8'h00;
      regRdValid <= 1'b0;
    end else begin
      regRdValid <= regRd;
      if (regRd) begin
        regRdData <= rdMux;
      end
    end
  end
endmodule

// ==== core/mic_defs.vh ====
// Register map, field positions, reset values and timing figures of the
// motion interrupt block. Included by the design files; definitions only.
`ifndef MIC_DEFS_VH
`define MIC_DEFS_VH

`define MIC_ADDR_ID 8'h00
`define MIC_ADDR_STAT_A 8'h0A
`define MIC_ADDR_STAT_B 8'h0B
`define MIC_ADDR_BUF_STATE 8'h0E
`define MIC_ADDR_ROUTE_B 8'h1C
`define MIC_ADDR_PIN_DRIVE 8'h20
`define MIC_ADDR_IRQ_BEH 8'h21
`define MIC_ADDR_FF_DELAY 8'h22
`define MIC_ADDR_FF_THR 8'h23
`define MIC_ADDR_HYST_MODE 8'h24
`define MIC_ADDR_SH_DELAY 8'h25
`define MIC_ADDR_SH_THR 8'h26
`define MIC_ADDR_X_TRIM 8'h27
`define MIC_ADDR_Y_TRIM 8'h28
`define MIC_ADDR_Z_TRIM 8'h29
`define MIC_ADDR_KNOCK_TIME 8'h2A
`define MIC_ADDR_KNOCK_THR 8'h2B
`define MIC_ADDR_ORIENT_Z 8'h2C
`define MIC_ADDR_BUF_MODE 8'h3E
`define MIC_ADDR_BUF_READ 8'h3F

`define MIC_RST_PIN_DRIVE 8'h05
`define MIC_RST_IRQ_BEH 8'h00
`define MIC_RST_FF_DELAY 8'h09
`define MIC_RST_FF_THR 8'h30
`define MIC_RST_HYST_MODE 8'h81
`define MIC_RST_SH_DELAY 8'h0F
`define MIC_RST_SH_THR 8'hC0
`define MIC_RST_KNOCK_TIME 8'h04
`define MIC_RST_ZERO 8'h00

// Event bit positions, shared by the route and status registers
`define MIC_EV_WATERMARK 6
`define MIC_EV_FULL 5
`define MIC_EV_DATA 4
`define MIC_EV_FREEFALL 2
`define MIC_EV_SHOCK 1
`define MIC_EV_SINGLE_KNOCK 5
`define MIC_EV_DOUBLE_KNOCK 4

// Pin drive fields
`define MIC_PIN_B_OPENDRAIN 3
`define MIC_PIN_B_POLARITY 2
`define MIC_PIN_A_OPENDRAIN 1
`define MIC_PIN_A_POLARITY 0

// Interrupt behaviour fields, and the free-fall sum mode bit of the hysteresis register
`define MIC_CLEAR_ON_ANY_READ 7
`define MIC_BYTE_LOCK_DISABLE 6
`define MIC_DRDY_HOLD 5
`define MIC_LATCH 0
`define MIC_FF_SUM_MODE 2

// Buffer geometry
`define MIC_BUF_WORDS 96
`define MIC_BUF_FRAMES 32
`define MIC_BUF_WATERMARK 16

// Timing figures
`define MIC_CLK_NS 10
`define MIC_MS_NS 1000000
`define MIC_DRDY_PULSE_NS 128000
`define MIC_DELAY_STEP_MS 10'h002
`define MIC_QUIET_LONG_MS 10'h01E
`define MIC_QUIET_SHORT_MS 10'h014
`define MIC_SHOCK_SHORT_MS 10'h032
`define MIC_SHOCK_LONG_MS 10'h04B

// Weights in units of 3.9 mg, sized to the threshold arithmetic
`define MIC_THR_UNIT 14'h0002
`define MIC_HYST_UNIT 14'h0020
`define MIC_KNOCK_UNIT 14'h0010

`endif

// ==== core/mic_fifo_mem.v ====
// Sample buffer storage: one write port, one read port, registered read data.
// Assumes the caller keeps addresses below the depth.
`timescale 1ns/1ns
`include "mic_defs.vh"
module mic_fifo_mem (
  // Clock
  input wire clk,
  // Write side
  input wire wrEn,
  input wire [6:0] wrAddr,
  input wire [9:0] wrData,
  // Read side
  input wire [6:0] rdAddr,
  output reg [9:0] rdData
);
  reg [9:0] store [0:`MIC_BUF_WORDS-1];

  always @(posedge clk) begin
    if (wrEn) begin
      store[wrAddr] <= wrData;
    end
    rdData <= store[rdAddr];
  end
endmodule

// ==== tb/mic_core_properties.sv ====
// Checker for the motion interrupt block: pin drive, routing and read timing.
// Sees only the top ports; keeps its own copy of the pin, behaviour and route settings.
`timescale 1ns/1ns
module mic_core_properties #(
  parameter DRDY_CYCLES = 8
) (
  // Clock and reset
  input wire clk,
  input wire srst,
  // Register port
  input wire regWr,
  input wire regRd,
  input wire [7:0] regAddr,
  input wire [7:0] regWrData,
  input wire regRdValid,
  // Sample path
  input wire convStart,
  input wire sampleReady,
  // Interrupt pins
  input wire irqAOut,
  input wire irqAOe,
  input wire irqBOut,
  input wire irqBOe
);
  reg [7:0] pinCfg;
  reg [7:0] behCfg;
  reg [7:0] routeB;
  reg [1:0] cfgAge;
  reg [15:0] bOn;
  wire cfgWr = regWr && (regAddr == 8'h20 || regAddr == 8'h21 || regAddr == 8'h1C);
  // Settings must have settled through the registered pins before judging
  wire steady = cfgAge == 2'h3;
  // Only telling for push-pull, where the pin shows both levels
  wire bAct = irqBOut == pinCfg[2];
  wire drdyOnly = steady && routeB == 8'h10 && !pinCfg[3];

  always @(posedge clk) begin
    if (srst) begin
      pinCfg <= 8'h05;
      behCfg <= 8'h00;
      routeB <= 8'h00;
      cfgAge <= 2'h0;
      bOn <= 16'h0000;
    end else begin
      if (regWr && regAddr == 8'h20) pinCfg <= regWrData;
      if (regWr && regAddr == 8'h21) behCfg <= regWrData;
      if (regWr && regAddr == 8'h1C) routeB <= regWrData;
      cfgAge <= cfgWr ? 2'h0 : (steady ? cfgAge : cfgAge + 2'h1);
      bOn <= bAct ? bOn + 16'h0001 : 16'h0000;
    end
  end

  default clocking cb @(posedge clk); endclocking
  default disable iff (srst);

  property p_rd_answer; regRd |=> regRdValid; endproperty
  a_rd_answer: assert property (p_rd_answer) else $error("read not answered");
  property p_rd_cause; regRdValid |-> $past(regRd); endproperty
  a_rd_cause: assert property (p_rd_cause) else $error("answer without read");
  property p_b_pushpull; steady && !pinCfg[3] |-> irqBOe; endproperty
  a_b_pushpull: assert property (p_b_pushpull) else $error("pin B not driven");
  property p_a_pushpull; steady && !pinCfg[1] |-> irqAOe; endproperty
  a_a_pushpull: assert property (p_a_pushpull) else $error("pin A not driven");
  property p_b_opendrain; steady && pinCfg[3] && irqBOe |-> !irqBOut; endproperty
  a_b_opendrain: assert property (p_b_opendrain) else $error("pin B drives high");
  property p_b_unrouted; steady && routeB == 8'h00 |-> !irqBOe || !bAct; endproperty
  a_b_unrouted: assert property (p_b_unrouted) else $error("pin B active unrouted");
  property p_drdy_route; drdyOnly && !behCfg[0] && sampleReady |-> ##2 bAct; endproperty
  a_drdy_route: assert property (p_drdy_route) else $error("data ready missing");
  // Latched status adds one register stage before the pin
  property p_drdy_latch; drdyOnly && behCfg[0] && sampleReady |-> ##3 bAct; endproperty
  a_drdy_latch: assert property (p_drdy_latch) else $error("latched ready missing");
  property p_drdy_pulse; drdyOnly && behCfg == 8'h00 |-> bOn <= DRDY_CYCLES + 2; endproperty
  a_drdy_pulse: assert property (p_drdy_pulse) else $error("pulse too long");
  property p_drdy_hold;
    drdyOnly && behCfg == 8'h20 && bAct && !convStart && !$past(convStart) |=> bAct;
  endproperty
  a_drdy_hold: assert property (p_drdy_hold) else $error("held data ready lost");
  property p_latch_hold;
    drdyOnly && behCfg == 8'h01 && bAct && !regRd && !$past(regRd) |=> bAct;
  endproperty
  a_latch_hold: assert property (p_latch_hold) else $error("latched event lost");
endmodule

bind mic_core mic_core_properties #(.DRDY_CYCLES(DRDY_CYCLES)) checker_i (.clk(clk), .srst(srst),
  .regWr(regWr), .regRd(regRd), .regAddr(regAddr), .regWrData(regWrData),
  .regRdValid(regRdValid), .convStart(convStart), .sampleReady(sampleReady),
  .irqAOut(irqAOut), .irqAOe(irqAOe), .irqBOut(irqBOut), .irqBOe(irqBOe));

// ==== tb/mic_host.sv ====
// Host model: byte register reads and writes, and pull-ups on both pins.
// Assumes requests are launched on the falling clock edge.
`timescale 1ns/1ns
module mic_host (
  // Clock
  input wire clk,
  // Register port
  output reg regWr,
  output reg regRd,
  output reg [7:0] regAddr,
  output reg [7:0] regWrData,
  // Interrupt pins
  input wire irqAOut,
  input wire irqAOe,
  input wire irqBOut,
  input wire irqBOe,
  output wire pinA,
  output wire pinB
);
  // Released lines float high through the pull-ups
  assign pinA = irqAOe ? irqAOut : 1'b1;
  assign pinB = irqBOe ? irqBOut : 1'b1;

  initial begin
    regWr = 1'b0;
    regRd = 1'b0;
    regAddr = 8'h00;
    regWrData = 8'h00;
  end

  // Idle cycle after each request keeps buffer reads spaced apart
  task xfer(input isWr, input [7:0] adr, input [7:0] dat);
    begin
      @(negedge clk);
      regWr = isWr;
      regRd = !isWr;
      regAddr = adr;
      regWrData = dat;
      @(negedge clk);
      regWr = 1'b0;
      regRd = 1'b0;
      regAddr = ~adr;
      regWrData = ~dat;
      @(negedge clk);
    end
  endtask
endmodule

// ==== tb/testbench.sv ====
// Bench for the motion interrupt block: host model on the register port,
// bench drives samples and conversion starts and watches both pins.
`timescale 1ns/1ns
module testbench;
  localparam [255:0] RST_TAB = {128'h2005_2100_2209_2330_2481_250F_26C0_2700,
    128'h2800_2900_2A04_2B00_2C00_1C00_3F00_F000};
  reg clk = 1'b0;
  reg srst = 1'b1;
  reg convStart = 1'b0;
  reg sampleReady = 1'b0;
  reg [29:0] sampleXyz = 30'h0000_0000;
  reg [1:0] fullScale = 2'h0;
  wire regWr, regRd, regRdValid, irqAOut, irqAOe, irqBOut, irqBOe, pinA, pinB;
  wire [7:0] regAddr, regWrData, regRdData;
  integer errTotal = 0;
  integer comparisons = 0;
  integer cycles = 0;
  integer seed = 61200;
  integer i;
  reg [15:0] expQ[$];
  reg [9:0] xa;
  reg [9:0] xb;

  always #5 clk = ~clk;

  mic_core #(.MS_CYCLES(10), .DRDY_CYCLES(8)) DUT (.clk(clk), .srst(srst), .regWr(regWr),
    .regRd(regRd), .regAddr(regAddr), .regWrData(regWrData), .regRdData(regRdData),
    .regRdValid(regRdValid), .convStart(convStart), .sampleReady(sampleReady),
    .sampleXyz(sampleXyz), .fullScale(fullScale), .irqAOut(irqAOut), .irqAOe(irqAOe),
    .irqBOut(irqBOut), .irqBOe(irqBOe));
  mic_host host (.clk(clk), .regWr(regWr), .regRd(regRd), .regAddr(regAddr),
    .regWrData(regWrData), .irqAOut(irqAOut), .irqAOe(irqAOe), .irqBOut(irqBOut),
    .irqBOe(irqBOe), .pinA(pinA), .pinB(pinB));

  task wrapUp;
    begin
      $display("comparisons %0d mismatches %0d", comparisons, errTotal);
      if (errTotal == 0 && comparisons > 0)
        $display("All tests passed");
      else
        $display("Some tests failed");
      $finish;
    end
  endtask

  task chkRd(input [7:0] got, input [15:0] note);
    begin
      comparisons = comparisons + 1;
      if ((got & note[15:8]) !== (note[7:0] & note[15:8])) begin
        errTotal = errTotal + 1;
        $display("wrong value at %0t: read %h expected %h", $time, got, note[7:0]);
      end
    end
  endtask

  task chkPin(input got, input exp);
    begin
      comparisons = comparisons + 1;
      if (got !== exp) begin
        errTotal = errTotal + 1;
        $display("wrong value at %0t: pin %b expected %b", $time, got, exp);
      end
    end
  endtask

  task wr(input [7:0] adr, input [7:0] dat);
    host.xfer(1'b1, adr, dat);
  endtask

  // Mask picks the bits whose value is known
  task rd(input [7:0] adr, input [7:0] mask, input [7:0] exp);
    begin
      expQ.push_back({mask, exp});
      host.xfer(1'b0, adr, 8'h00);
    end
  endtask

  task sample(input [29:0] v);
    begin
      @(negedge clk);
      sampleXyz = v;
      sampleReady = 1'b1;
      @(negedge clk);
      sampleReady = 1'b0;
      sampleXyz = ~v;
    end
  endtask

  task waitN(input integer n);
    repeat (n) @(negedge clk);
  endtask

  always @(posedge clk) begin
    if (regRdValid === 1'b1) begin
      if (expQ.size() > 0) begin
        chkRd(regRdData, expQ.pop_front());
      end else begin
        errTotal = errTotal + 1;
        $display("wrong value at %0t: unexpected read answer", $time);
      end
    end
  end

  always @(posedge clk) begin
    cycles = cycles + 1;
    if (cycles == 3000) begin
      errTotal = errTotal + 1;
      wrapUp;
    end
  end

  initial begin
    repeat (5) @(negedge clk);
    srst = 1'b0;
    for (i = 0; i < 16; i = i + 1) begin
      rd(RST_TAB[255 - 16 * i -: 8], 8'hFF, RST_TAB[247 - 16 * i -: 8]);
    end
    for (i = 0; i < 5; i = i + 1) begin
      xa = $random(seed);
      wr(8'h25 + i[7:0], xa[7:0]);
      rd(8'h25 + i[7:0], 8'hFF, xa[7:0]);
      wr(8'h25 + i[7:0], 8'h00);
    end
    wr(8'h3F, xa[7:0]);
    rd(8'h3F, 8'hFF, 8'h00);
    // Knock threshold at top keeps pin A quiet for small samples
    wr(8'h2B, 8'h1F);
    wr(8'h1C, 8'h10);
    wr(8'h21, 8'h01);
    for (i = 0; i < 4; i = i + 1) begin
      wr(8'h20, {4'h0, i[1:0], i[1:0]});
      waitN(3);
      chkPin(pinA, !i[0]);
      chkPin(pinB, !i[0]);
      sample(30'h0000_00C8);
      waitN(2);
      chkPin(pinB, i[0]);
      rd(8'h20, 8'h0F, {4'h0, i[1:0], i[1:0]});
      chkPin(pinB, i[0]);
      // Set beats clear, so the clear read waits out the data-ready pulse
      waitN(3);
      rd(8'h0B, 8'h10, 8'h10);
      waitN(1);
      chkPin(pinB, !i[0]);
    end
    wr(8'h20, 8'h05);
    wr(8'h21, 8'h00);
    waitN(1);
    sample(30'h0000_00C8);
    waitN(6);
    chkPin(pinB, 1'b1);
    waitN(8);
    chkPin(pinB, 1'b0);
    wr(8'h21, 8'h20);
    sample(30'h0000_00C8);
    waitN(30);
    chkPin(pinB, 1'b1);
    @(negedge clk) convStart = 1'b1;
    @(negedge clk) convStart = 1'b0;
    waitN(3);
    chkPin(pinB, 1'b0);
    wr(8'h1C, 8'h00);
    sample(30'h0000_00C8);
    waitN(3);
    chkPin(pinB, 1'b0);
    for (i = 0; i < 2; i = i + 1) begin
      wr(8'h21, {1'b0, i[0], 6'h00});
      xa = $random(seed);
      xb = $random(seed);
      sample({20'h0_0000, xa});
      rd(8'h01, 8'hC1, {xa[1:0], 6'h01});
      sample({20'h0_0000, xb});
      rd(8'h02, 8'hFF, i[0] ? xb[9:2] : xa[9:2]);
    end
    // Persistence of 8 ms, well clear of the tick granularity
    wr(8'h22, 8'h03);
    wr(8'h1C, 8'h04);
    sample(30'h0000_00C8);
    for (i = 0; i < 26; i = i + 1) begin
      sample(30'h0000_0000);
      waitN(2);
      if (i == 14) chkPin(pinB, 1'b0);
    end
    chkPin(pinB, 1'b1);
    sample(30'h0000_00C8);
    waitN(3);
    chkPin(pinB, 1'b0);
    // X only: one word per sample, low byte flagged valid, pop on high byte
    wr(8'h3E, 8'h01);
    sample({20'h0_0000, xa});
    rd(8'h0E, 8'hFF, 8'h01);
    rd(8'h3F, 8'hFF, {xa[1:0], 6'h01});
    rd(8'h3F, 8'hFF, xa[9:2]);
    rd(8'h3F, 8'hFF, 8'h00);
    waitN(3);
    wrapUp;
  end
endmodule
